// File: logic/cre_pkg.sv
// Purpose: shared constants and types for the system-control instruction unit
// Assumes: 32-bit APB register window, one aligned word per register
// Notes:   status bit positions and the shadow-set layout are local to this unit
package cre_pkg;

  // register byte offsets
  localparam logic [7:0] REG_INSTR   = 8'h00;
  localparam logic [7:0] REG_SRC     = 8'h04;
  localparam logic [7:0] REG_STATUS  = 8'h08;
  localparam logic [7:0] REG_EXCPC   = 8'h0C;
  localparam logic [7:0] REG_ERRPC   = 8'h10;
  localparam logic [7:0] REG_SHADOW  = 8'h14;
  localparam logic [7:0] REG_CONFIG  = 8'h18;
  localparam logic [7:0] REG_RESULT  = 8'h1C;
  localparam logic [7:0] REG_INFO    = 8'h20;
  localparam logic [7:0] REG_PC      = 8'h24;
  localparam logic [7:0] REG_FLAGS   = 8'h28;

  // status fields
  localparam int ST_IRQ_ON   = 0;
  localparam int ST_EXC_LVL  = 1;
  localparam int ST_ERR_LVL  = 2;
  localparam int ST_BOOT_VEC = 22;
  localparam logic [31:0] STATUS_RST = 32'h00400004;

  // shadow-set control fields
  localparam int SH_CUR_LO  = 0;
  localparam int SH_PREV_LO = 6;
  localparam int SH_HIGH_LO = 26;
  localparam int SH_W       = 4;
  localparam logic [31:0] SHADOW_RST = 32'h00000000;

  // configuration fields
  localparam int CF_REV2     = 0;
  localparam int CF_CP_EN    = 1;
  localparam int CF_ALT_ISA  = 2;
  localparam int CF_COMPRESS = 3;
  localparam logic [4:0] CONFIG_RST = 5'h03;

  // info fields
  localparam int IN_TGT_LO   = 0;
  localparam int IN_TGT_WR   = 8;
  localparam int IN_RSVD_EXC = 9;
  localparam int IN_CPU_EXC  = 10;
  localparam int IN_REDIRECT = 11;
  localparam int IN_ISSUE    = 12;
  localparam int IN_BARRIER  = 13;
  localparam int IN_UNKNOWN  = 14;
  localparam int IN_CNT_LO   = 16;

  // flag fields
  localparam int FL_ISA     = 0;
  localparam int FL_LINK    = 1;
  localparam int FL_HAZARD  = 2;

  // instruction encodings
  localparam logic [31:0] ENC_BARRIER = 32'h000000C0;
  localparam logic [31:0] ENC_HOLDNOP = 32'h00000040;
  localparam logic [5:0]  OPC_SYSCP   = 6'h10;
  localparam logic [4:0]  SUB_MISC    = 5'h0B;
  localparam logic [4:0]  RD_MISC     = 5'h0C;
  localparam logic [5:0]  FN_RETURN   = 6'h18;
  localparam logic [5:0]  OPC_GROUP3  = 6'h1F;
  localparam logic [5:0]  FN_PULL     = 6'h00;
  localparam int          SEL_BIT     = 5;

  typedef enum logic [2:0] {
    OP_NONE, OP_HOLDNOP, OP_BARRIER, OP_IRQ_ON, OP_IRQ_OFF, OP_RETURN, OP_PULL
  } cre_op_t;

endpackage : cre_pkg

// File: logic/cre_decoder.sv
// Purpose: classify one instruction word for the system-control unit
// Assumes: purely combinational, word is stable while examined
// Notes:   anything not listed reads as OP_NONE
`timescale 1ns/10ps
`default_nettype none
module cre_decoder
  import cre_pkg::*;
(
  // instruction
  input  wire logic [31:0] instr,
  // classification
  output cre_op_t          op,
  output logic [4:0]       tgtIdx,
  output logic [4:0]       srcIdx,
  output logic [4:0]       sizeM1,
  output logic [4:0]       lowPos
);

  logic miscMatch;

  assign tgtIdx = instr[20:16];
  assign srcIdx = instr[25:21];
  assign sizeM1 = instr[15:11]; // RULE_19
  assign lowPos = instr[10:6];  // RULE_19

  // empty target field already encodes r0, so nothing special is needed here
  assign miscMatch = (instr[31:26] == OPC_SYSCP) && (instr[25:21] == SUB_MISC) &&
                     (instr[15:11] == RD_MISC) && (instr[10:6] == 5'h00) &&
                     (instr[4:0] == 5'h00); // RULE_04 RULE_06

  always_comb begin
    op = OP_NONE;
    if (instr == ENC_BARRIER) begin // RULE_03
      op = OP_BARRIER;
    end else if (instr == ENC_HOLDNOP) begin
      op = OP_HOLDNOP;
    end else if (miscMatch) begin
      op = instr[SEL_BIT] ? OP_IRQ_ON : OP_IRQ_OFF; // RULE_04
    end else if ((instr[31:26] == OPC_SYSCP) && instr[25] && (instr[24:6] == 19'h00000) &&
                 (instr[5:0] == FN_RETURN)) begin // RULE_11
      op = OP_RETURN;
    end else if ((instr[31:26] == OPC_GROUP3) && (instr[5:0] == FN_PULL)) begin // RULE_19
      op = OP_PULL;
    end
  end

endmodule : cre_decoder
`default_nettype wire

// File: logic/cre_extract.sv
// Purpose: zero-extending bit-field extract
// Assumes: lowPos + sizeM1 stays within the word; otherwise the result is don't-care
// Notes:   mask built bit by bit so no 33-bit shift is needed for a full-width field
`timescale 1ns/10ps
`default_nettype none
module cre_extract #(
  parameter int W = 32
) (
  // operands
  input  wire logic [W-1:0] src,
  input  wire logic [4:0]   lowPos,
  input  wire logic [4:0]   sizeM1,
  // result
  output logic [W-1:0]      result
);

  logic [W-1:0] shifted;
  logic [W-1:0] mask;

  assign shifted = src >> lowPos; // RULE_20

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_mask
      assign mask[i] = (i <= int'(sizeM1)); // RULE_20
    end
  endgenerate

  assign result = shifted & mask; // RULE_20

endmodule : cre_extract
`default_nettype wire

// File: logic/cre_top.sv
// Purpose: executes barrier, interrupt-enable, exception-return and extract over APB
// Assumes: one instruction executes per write to the instruction register
// Notes on behaviour
// RULE_01 - revision-two barrier clears all pending hazards and also holds issue
// RULE_02 - revision-one core runs the barrier word exactly as a superscalar no-op
// RULE_03 - barrier is the shift word with zero registers and shift amount three
// RULE_04 - enable is the misc-move group form; its select bit picks enable or disable
// RULE_05 - enable copies whole status to target register, then sets interrupt enable
// RULE_06 - target field of zero means register zero, so the old status is dropped
// RULE_07 - enable and return raise coprocessor unusable when access is off
// RULE_08 - before revision two, enable and extract raise reserved instruction
// RULE_09 - status read and enable set happen in one indivisible cycle
// RULE_10 - enable change lands late; barrier, barrier jumps and return make it land
// RULE_11 - return matches its exact opcode, coprocessor bit, zero field and function
// RULE_12 - return has no delay slot; fetch goes straight to the chosen address
// RULE_13 - software never puts a return in a branch delay slot
// RULE_14 - return clears the link flag so a later conditional store fails
// RULE_15 - return clears every hazard before the target fetch
// RULE_16 - error level picks error pc and clears it, else exception pc and level
// RULE_17 - shadow set restored only for rev2, highest above zero, no boot, no error
// RULE_18 - with a compressed set, pc bit zero cleared and moved into set mode
// RULE_19 - extract matches group three, function zero; size and low fields decoded
// RULE_20 - extract right-justifies the field and zero-fills the upper bits
// RULE_21 - software keeps low plus size-minus-one at or below 31
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module cre_top
  import cre_pkg::*;
#(
  parameter int W = 32
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // core side
  input  wire logic        jumpBarrier,
  output logic             globalIrqOn,
  output logic             issueHold,
  output logic             pcRedirect,
  output logic [31:0]      redirectPc,
  output logic             instrSetSel
);

  // register map check used by the setup-phase refusal; the access-phase write checks writable
  function automatic logic mapped(input logic [7:0] a);
    unique case (a)
      REG_INSTR, REG_SRC, REG_STATUS, REG_EXCPC, REG_ERRPC, REG_SHADOW,
      REG_CONFIG, REG_RESULT, REG_INFO, REG_PC, REG_FLAGS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction : mapped

  function automatic logic writable(input logic [7:0] a);
    unique case (a)
      REG_INSTR, REG_SRC, REG_STATUS, REG_EXCPC, REG_ERRPC, REG_SHADOW,
      REG_CONFIG, REG_FLAGS: writable = 1'b1;
      default: writable = 1'b0;
    endcase
  endfunction : writable

  // state held by this unit; everything after it is decode
  logic [31:0] instr_r;
  logic [31:0] src_r;
  logic [31:0] status_r;
  logic [31:0] excPc_r;
  logic [31:0] errPc_r;
  logic [31:0] shadow_r;
  logic [4:0]  config_r;
  logic [31:0] result_r;
  logic [31:0] info_r;
  logic [31:0] pc_r;
  logic        link_r;
  logic        hazard_r;
  logic        effIrq_r;
  logic        issue_r;
  logic        redirect_r;
  logic        isa_r;
  logic [7:0]  count_r;

  // per-word decode and the qualified execute strobes
  logic        access;
  logic        wrAcc;
  logic        exec;
  cre_op_t     op;
  logic [4:0]  tgtIdx;
  logic [4:0]  sizeM1;
  logic [4:0]  lowPos;
  logic [31:0] pulled;
  logic        rev2;
  logic        cpEn;
  logic        compressed;
  logic        rsvdExc;
  logic        cpuExc;
  logic        doIrqOn;
  logic        doIrqOff;
  logic        doReturn;
  logic        doPull;
  logic        doBarrier;
  logic        doHoldNop;
  logic        clearHaz;
  logic        setHaz;
  logic [31:0] retTemp;
  logic        shadowRestore;

  // pready is a plain decode: no register here ever needs a wait state
  assign access = psel && penable;
  assign wrAcc  = access && pwrite && writable(paddr);
  assign exec   = wrAcc && (paddr == REG_INSTR);
  assign pready = access;

  // decoding looks at the incoming word, so execution and the write share one edge
  cre_decoder u_dec (
    .instr  (pwdata),
    .op     (op),
    .tgtIdx (tgtIdx),
    .srcIdx (),
    .sizeM1 (sizeM1),
    .lowPos (lowPos)
  );

  // fields come from the incoming word, the operand from the source register
  cre_extract #(.W(W)) u_ext (
    .src    (src_r),
    .lowPos (lowPos),
    .sizeM1 (sizeM1),
    .result (pulled)
  );

  assign rev2       = config_r[CF_REV2];
  assign cpEn       = config_r[CF_CP_EN];
  assign compressed = config_r[CF_COMPRESS] || config_r[CF_ALT_ISA];

  // an instruction that does not exist on this revision wins over the access check
  assign rsvdExc = exec && !rev2 && ((op == OP_IRQ_ON) || (op == OP_IRQ_OFF) ||
                                     (op == OP_PULL)); // RULE_08
  assign cpuExc  = exec && !rsvdExc && !cpEn &&
                   ((op == OP_IRQ_ON) || (op == OP_IRQ_OFF) || (op == OP_RETURN)); // RULE_07

  assign doIrqOn   = exec && !rsvdExc && !cpuExc && (op == OP_IRQ_ON);
  assign doIrqOff  = exec && !rsvdExc && !cpuExc && (op == OP_IRQ_OFF);
  assign doReturn  = exec && !cpuExc && (op == OP_RETURN);
  assign doPull    = exec && !rsvdExc && (op == OP_PULL);
  assign doBarrier = exec && (op == OP_BARRIER) && rev2; // RULE_01
  // on revision one the barrier word is nothing more than the issue-holding no-op
  assign doHoldNop = exec && ((op == OP_HOLDNOP) || (op == OP_BARRIER)); // RULE_01 RULE_02

  assign clearHaz = doBarrier || doReturn || jumpBarrier; // RULE_10 RULE_15
  assign setHaz   = doIrqOn || doIrqOff || (wrAcc && (paddr == REG_STATUS));

  // error level wins: a reset-class entry never saved the exception pc
  assign retTemp = status_r[ST_ERR_LVL] ? errPc_r : excPc_r; // RULE_16
  assign shadowRestore = doReturn && !status_r[ST_ERR_LVL] && rev2 &&
                         (shadow_r[SH_HIGH_LO +: SH_W] != 4'h0) &&
                         !status_r[ST_BOOT_VEC]; // RULE_17

  // plain software-written registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      instr_r  <= 32'h00000000;
      src_r    <= 32'h00000000;
      excPc_r  <= 32'h00000000;
      errPc_r  <= 32'h00000000;
      config_r <= CONFIG_RST;
    end else if (wrAcc) begin
      unique case (paddr)
        REG_INSTR:  instr_r  <= pwdata;
        REG_SRC:    src_r    <= pwdata;
        REG_EXCPC:  excPc_r  <= pwdata;
        REG_ERRPC:  errPc_r  <= pwdata;
        REG_CONFIG: config_r <= pwdata[4:0];
        default: ;
      endcase
    end
  end

  // status: the read into the result and the enable update share one edge,
  // so nothing can be taken between them
  always_ff @(posedge clk) begin
    if (!rstn) begin
      status_r <= STATUS_RST;
    end else if (wrAcc && (paddr == REG_STATUS)) begin
      status_r <= pwdata;
    end else if (doIrqOn) begin
      status_r[ST_IRQ_ON] <= 1'b1; // RULE_05 RULE_09
    end else if (doIrqOff) begin
      status_r[ST_IRQ_ON] <= 1'b0;
    end else if (doReturn) begin
      if (status_r[ST_ERR_LVL]) begin
        status_r[ST_ERR_LVL] <= 1'b0; // RULE_16
      end else begin
        status_r[ST_EXC_LVL] <= 1'b0; // RULE_16
      end
    end
  end

  // shadow-set control
  // at error level no previous set was saved, so nothing is restored
  always_ff @(posedge clk) begin
    if (!rstn) begin
      shadow_r <= SHADOW_RST;
    end else if (wrAcc && (paddr == REG_SHADOW)) begin
      shadow_r <= pwdata;
    end else if (shadowRestore) begin
      shadow_r[SH_CUR_LO +: SH_W] <= shadow_r[SH_PREV_LO +: SH_W]; // RULE_17
    end
  end

  // link flag: software sets it to stand in for a load-linked
  // set and clear cannot meet: each needs its own bus access
  always_ff @(posedge clk) begin
    if (!rstn) begin
      link_r <= 1'b0;
    end else if (doReturn) begin
      link_r <= 1'b0; // RULE_14
    end else if (wrAcc && (paddr == REG_FLAGS) && pwdata[FL_LINK]) begin
      link_r <= 1'b1;
    end
  end

  // hazard tracking; a new status change in the same cycle as a barrier stays pending
  // limitation: a register jump that meets a status write is absorbed; software repeats it
  always_ff @(posedge clk) begin
    if (!rstn) begin
      hazard_r <= 1'b0;
      effIrq_r <= 1'b0;
    end else if (setHaz) begin
      hazard_r <= 1'b1; // RULE_10
    end else if (clearHaz) begin
      hazard_r <= 1'b0; // RULE_10 RULE_15
      effIrq_r <= status_r[ST_IRQ_ON]; // RULE_10
    end
  end

  // return target; nothing sequential runs after it
  // without a compressed set the mode bit keeps its old value
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pc_r  <= 32'h00000000;
      isa_r <= 1'b0;
    end else if (doReturn) begin
      if (compressed) begin
        pc_r  <= {retTemp[31:1], 1'b0}; // RULE_18
        isa_r <= retTemp[0];            // RULE_18
      end else begin
        pc_r  <= retTemp; // RULE_12
      end
    end
  end

  // one-cycle pulses to the core
  always_ff @(posedge clk) begin
    if (!rstn) begin
      issue_r    <= 1'b0;
      redirect_r <= 1'b0;
    end else begin
      issue_r    <= doHoldNop; // RULE_01 RULE_02
      redirect_r <= doReturn; // RULE_12
    end
  end

  // result word and info of the last executed instruction
  always_ff @(posedge clk) begin
    if (!rstn) begin
      result_r <= 32'h00000000;
      info_r   <= 32'h00000000;
      count_r  <= 8'h00;
    end else if (exec) begin
      // exceptions still count, so software can see the word was taken
      count_r <= count_r + 8'h01;
      info_r  <= 32'h00000000;
      info_r[IN_CNT_LO +: 8]   <= count_r + 8'h01;
      info_r[IN_RSVD_EXC]      <= rsvdExc;
      info_r[IN_CPU_EXC]       <= cpuExc;
      info_r[IN_REDIRECT]      <= doReturn;
      info_r[IN_ISSUE]         <= doHoldNop;
      info_r[IN_BARRIER]       <= doBarrier || doReturn;
      info_r[IN_UNKNOWN]       <= (op == OP_NONE);
      if (doIrqOn || doIrqOff) begin
        result_r <= status_r; // RULE_05 RULE_06
        info_r[IN_TGT_LO +: 5] <= tgtIdx;
        info_r[IN_TGT_WR]      <= 1'b1;
      end else if (doPull) begin
        result_r <= pulled; // RULE_20
        info_r[IN_TGT_LO +: 5] <= tgtIdx;
        info_r[IN_TGT_WR]      <= 1'b1;
      end
    end
  end

  // refusal is decided in the setup cycle so it already stands when pready rises
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= !mapped(paddr) || (pwrite && !writable(paddr));
    end
  end

  // read data is captured in the setup cycle; zero-wait access follows
  always_ff @(posedge clk) begin
    if (!rstn) begin
      prdata  <= 32'h00000000;
    end else if (psel && !penable) begin
      prdata  <= 32'h00000000;
      if (!pwrite) begin
        unique case (paddr)
          REG_INSTR:  prdata <= instr_r;
          REG_SRC:    prdata <= src_r;
          REG_STATUS: prdata <= status_r;
          REG_EXCPC:  prdata <= excPc_r;
          REG_ERRPC:  prdata <= errPc_r;
          REG_SHADOW: prdata <= shadow_r;
          REG_CONFIG: prdata <= {27'h0000000, config_r};
          REG_RESULT: prdata <= result_r;
          REG_INFO:   prdata <= info_r;
          REG_PC:     prdata <= pc_r;
          REG_FLAGS:  prdata <= {29'h00000000, hazard_r, link_r, isa_r};
          default:    prdata <= 32'h00000000;
        endcase
      end
    end
  end

  assign globalIrqOn = effIrq_r;
  assign issueHold   = issue_r;
  assign pcRedirect  = redirect_r;
  assign redirectPc  = pc_r;
  assign instrSetSel = isa_r;

endmodule : cre_top
`default_nettype wire

// File: verif/cre_top_monitor.sv
// Purpose: port-level temporal checks for cre_top
// Assumes: one clock, rstn synchronous active low
// Notes: config bits are not visible here, so outputs are tied to their causes
`timescale 1ns/10ps
`default_nettype none
module cre_top_monitor
  import cre_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // core side
  input wire logic        jumpBarrier,
  input wire logic        globalIrqOn,
  input wire logic        issueHold,
  input wire logic        pcRedirect,
  input wire logic [31:0] redirectPc,
  input wire logic        instrSetSel
);
  localparam logic [31:0] RET = {OPC_SYSCP, 1'b1, 19'h0, FN_RETURN};
  logic instrWr;
  logic retWr;
  logic nopWr;
  logic syncCause;
  assign instrWr = psel && penable && pwrite && paddr == REG_INSTR;
  assign retWr = instrWr && pwdata == RET;
  assign nopWr = instrWr && (pwdata == ENC_BARRIER || pwdata == ENC_HOLDNOP);
  assign syncCause = jumpBarrier || nopWr || retWr;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  sequence sRedirOnce;
    pcRedirect ##1 !pcRedirect;
  endsequence
  sequence sHoldOnce;
    issueHold ##1 !issueHold;
  endsequence
  chk_ready_zero_wait: assert property (pready == (psel && penable))
    else $error("pready not zero wait");
  chk_redirect_cause: assert property (pcRedirect |-> $past(retWr))
    else $error("redirect without return");
  chk_redirect_pulse: assert property ($rose(pcRedirect) |-> sRedirOnce)
    else $error("redirect not one cycle");
  chk_hold_cause: assert property (issueHold |-> $past(nopWr))
    else $error("hold without no-op");
  chk_hold_pulse: assert property ($rose(issueHold) |-> sHoldOnce)
    else $error("hold not one cycle");
  chk_irq_late: assert property ($changed(globalIrqOn) |-> $past(syncCause) || $past(syncCause, 2))
    else $error("irq enable moved without barrier");
  chk_isa_redirect: assert property ($changed(instrSetSel) |-> pcRedirect)
    else $error("mode changed outside return");
  chk_pc_redirect: assert property ($changed(redirectPc) |-> pcRedirect)
    else $error("pc changed outside return");
  chk_unmapped_err: assert property (psel && penable && paddr > REG_FLAGS |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
endmodule : cre_top_monitor
`default_nettype wire

// File: verif/cre_core_model.sv
// Purpose: core-side partner: issues barrier jumps, follows redirects
// Assumes: same clock and reset as the unit
// Notes: counters let the bench see one-cycle pulses after the fact
`timescale 1ns/10ps
`default_nettype none
module cre_core_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // bench command
  input  wire logic        jumpReq,
  // unit outputs
  input  wire logic        pcRedirect,
  input  wire logic        issueHold,
  input  wire logic [31:0] redirectPc,
  // observations
  output logic             jumpBarrier,
  output logic [31:0]      fetchPc,
  output logic [7:0]       redirCnt,
  output logic [7:0]       holdCnt
);
  // never jump as a return lands: a return is never in a delay slot
  always_ff @(posedge clk) begin
    if (!rstn)
      jumpBarrier <= 1'b0;
    else
      jumpBarrier <= jumpReq && !pcRedirect;
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      fetchPc <= 32'h0;
      redirCnt <= 8'h0;
    end else if (pcRedirect) begin
      fetchPc <= redirectPc;
      redirCnt <= redirCnt + 8'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn)
      holdCnt <= 8'h0;
    else if (issueHold)
      holdCnt <= holdCnt + 8'h1;
  end
endmodule : cre_core_model
`default_nettype wire

// File: verif/cp0_return_enable_extract_test.sv
// Purpose: self-checking bench for cre_top
// Assumes: zero-wait apb slave, registered read data
// Notes: reads are scored by a queue watcher at the access edge
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin samplesChecked++; if ((g) !== (e)) begin failCount++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module cp0_return_enable_extract_test;
  import cre_pkg::*;
  typedef struct packed {logic err; logic [31:0] mask; logic [31:0] data;} cre_note_t;
  localparam logic [31:0] RET = {OPC_SYSCP, 1'b1, 19'h0, FN_RETURN};
  logic clk, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, jumpReq = 1'b0;
  logic [7:0] paddr = 8'h0, redirCnt, holdCnt, c;
  logic [31:0] pwdata = 32'h0, prdata, redirectPc, fetchPc, st, a, b, t, s;
  logic pready, pslverr, jumpBarrier, globalIrqOn, issueHold, pcRedirect, instrSetSel;
  logic [4:0] lo, m;
  int failCount = 0, samplesChecked = 0;
  cre_note_t q[$];
  cre_note_t n;
  cre_top uut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .jumpBarrier(jumpBarrier), .globalIrqOn(globalIrqOn), .issueHold(issueHold),
    .pcRedirect(pcRedirect), .redirectPc(redirectPc), .instrSetSel(instrSetSel));
  cre_core_model core (.clk(clk), .rstn(rstn), .jumpReq(jumpReq), .pcRedirect(pcRedirect),
    .issueHold(issueHold), .redirectPc(redirectPc), .jumpBarrier(jumpBarrier),
    .fetchPc(fetchPc), .redirCnt(redirCnt), .holdCnt(holdCnt));
  task automatic wrapUp();
    if (failCount == 0 && samplesChecked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrapUp
  task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] d, input cre_note_t nt);
    int k;
    q.push_back(nt);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      failCount++;
      wrapUp();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    // two idle edges let registered side effects settle before checks
    repeat (2) @(posedge clk);
  endtask : xfer
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    xfer(1'b1, ad, d, '{1'b0, 32'h0, 32'h0});
  endtask : wr
  task automatic rd(input logic [7:0] ad, input logic [31:0] e, input logic [31:0] mk);
    xfer(1'b0, ad, 32'h0, '{1'b0, mk, e});
  endtask : rd
  always @(posedge clk) begin
    if (rstn && psel && penable && pready && q.size() > 0) begin
      n = q.pop_front();
      `CHK(pslverr, n.err)
      `CHK(prdata & n.mask, n.data & n.mask)
    end
  end
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    void'($urandom(32'hE655B34E));
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(REG_STATUS, STATUS_RST, '1);
    rd(REG_SHADOW, SHADOW_RST, '1);
    rd(REG_CONFIG, {27'h0, CONFIG_RST}, '1);
    xfer(1'b0, 8'h40, 32'h0, '{1'b1, '1, 32'h0});
    xfer(1'b1, REG_RESULT, 32'h5, '{1'b1, 32'h0, 32'h0});
    for (int i = 0; i < 2; i++) begin
      st = $urandom & 32'h00400006;
      t = i ? 32'($urandom % 31 + 1) : 32'h0;
      wr(REG_STATUS, st);
      wr(REG_INSTR, 32'h41606020 | (t << 16));
      rd(REG_RESULT, st, '1);
      rd(REG_STATUS, st | 32'h1, '1);
      rd(REG_INFO, t, 32'h0000461F);
      `CHK(globalIrqOn, 1'b0)
    end
    c = holdCnt;
    wr(REG_INSTR, ENC_BARRIER);
    `CHK(globalIrqOn, 1'b1)
    wr(REG_INSTR, ENC_HOLDNOP);
    `CHK(holdCnt, c + 8'h2)
    wr(REG_INSTR, 32'h41606000);
    `CHK(globalIrqOn, 1'b1)
    jumpReq <= 1'b1;
    @(posedge clk);
    jumpReq <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK(globalIrqOn, 1'b0)
    for (int k = 0; k < 5; k++) begin
      a = $urandom;
      b = $urandom;
      wr(REG_CONFIG, k[1] ? (k[0] ? 32'h7 : 32'hB) : 32'h3);
      wr(REG_EXCPC, a);
      wr(REG_ERRPC, b);
      wr(REG_SHADOW, 32'h0C000140);
      wr(REG_STATUS, k == 4 ? 32'h00400002 : (k[0] ? 32'h6 : 32'h2));
      wr(REG_FLAGS, 32'h2);
      c = redirCnt;
      wr(REG_INSTR, RET);
      t = k[0] ? b : a;
      `CHK(redirCnt, c + 8'h1)
      `CHK(fetchPc, k[1] ? {t[31:1], 1'b0} : t)
      if (k[1]) `CHK(instrSetSel, t[0])
      rd(REG_STATUS, k == 4 ? 32'h00400000 : (k[0] ? 32'h2 : 32'h0), '1);
      rd(REG_SHADOW, (k[0] || k == 4) ? 32'h0C000140 : 32'h0C000145, '1);
      rd(REG_FLAGS, 32'h0, 32'h6);
    end
    c = redirCnt;
    wr(REG_INSTR, RET | 32'h40);
    rd(REG_INFO, 32'h4000, 32'h4E00);
    `CHK(redirCnt, c)
    wr(REG_CONFIG, 32'h3);
    for (int i = 0; i < 10; i++) begin
      lo = (i == 0) ? 5'h0 : (i == 1) ? 5'h1F : 5'($urandom);
      m = (i == 0) ? 5'h1F : 5'($urandom % (32 - lo));
      s = $urandom;
      wr(REG_SRC, s);
      wr(REG_INSTR, {OPC_GROUP3, 5'h3, 5'h4, m, lo, FN_PULL});
      rd(REG_RESULT, (s >> lo) & (32'hFFFFFFFF >> (31 - m)), '1);
    end
    for (int i = 0; i < 2; i++) begin
      wr(REG_CONFIG, i ? 32'h1 : 32'h2);
      wr(REG_STATUS, 32'h0);
      wr(REG_INSTR, 32'h41606020);
      rd(REG_INFO, i ? 32'h400 : 32'h200, 32'h600);
      rd(REG_STATUS, 32'h0, '1);
      c = holdCnt;
      wr(REG_INSTR, ENC_BARRIER);
      `CHK(holdCnt, c + 8'h1)
      rd(REG_FLAGS, i ? 32'h0 : 32'h4, 32'h4);
      wr(REG_INSTR, i ? RET : {OPC_GROUP3, 20'h0, FN_PULL});
      rd(REG_INFO, i ? 32'h400 : 32'h200, 32'h600);
    end
    wrapUp();
  end
endmodule : cp0_return_enable_extract_test
bind cre_top cre_top_monitor chk (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .jumpBarrier(jumpBarrier), .globalIrqOn(globalIrqOn),
  .issueHold(issueHold), .pcRedirect(pcRedirect), .redirectPc(redirectPc),
  .instrSetSel(instrSetSel));
`default_nettype wire
